// File: rtl/programmable_down_timer_consts.svh
// constants for the programmable down timer
// Function
// - two-bit prescaler ratio, code 10 divides 32
// - two-bit source select: high, low, pin, filtered
// - noise rejector clock 1024 or 256 Hz
// - overflow reaches output only when enabled
// - run bit gates counting, resets stopped
// - writing one to reload bit loads counter
// - reload value in two read/write nibbles
// - live count in two read-only nibbles
// - timer interrupt mask bit, resets masked
// - read-only interrupt factor flag, resets zero
// - overflow on shared pin only when selected
`ifndef PROGRAMMABLE_DOWN_TIMER_CONSTS_SVH
`define PROGRAMMABLE_DOWN_TIMER_CONSTS_SVH

// ***************************
// register addresses
// ***************************
`define ADDR_PRESCALE    8'hE8
`define ADDR_SOURCE      8'hE9
`define ADDR_CONTROL     8'hEA
`define ADDR_RELOAD_LO   8'hEB
`define ADDR_RELOAD_HI   8'hEC
`define ADDR_COUNT_LO    8'hED
`define ADDR_COUNT_HI    8'hEE
`define ADDR_IRQ_MASK    8'hF0
`define ADDR_IRQ_FLAG    8'hF8

// ***************************
// control field positions
// ***************************
`define CTRL_FORCE_RELOAD 0
`define CTRL_RUN          1
`define CTRL_OUT_ENABLE   2
`define CTRL_FILTER_RATE  3

// ***************************
// reset values
// ***************************
`define RST_FIELD2  2'h0
`define RST_NIBBLE  4'h0
`define RST_BYTE    8'h00
`define RST_BIT     1'h0

// ***************************
// prescaler ratios (divide by value)
// ***************************
`define PS_DIV_0  8'h01
`define PS_DIV_1  8'h04
`define PS_DIV_2  8'h20
`define PS_DIV_3  8'h80

// ***************************
// timing
// ***************************
`define CLK_HZ       50000000
`define NR_FAST_HZ   1024
`define NR_SLOW_HZ   256
`define NR_CNT_W     18

`endif

// File: rtl/timer_pkg.sv
// types shared by the programmable down timer
package timer_pkg;

  typedef enum logic [1:0] {
    SRC_FILTERED = 2'h0,
    SRC_PIN      = 2'h1,
    SRC_LOW_OSC  = 2'h2,
    SRC_HIGH_OSC = 2'h3
  } count_source_e;

  typedef enum logic [1:0] {
    NR_LOW       = 2'h0,
    NR_RISE_CHK  = 2'h1,
    NR_HIGH      = 2'h3,
    NR_FALL_CHK  = 2'h2
  } rejector_state_e;

endpackage

// File: rtl/timer_cfg_if.sv
// carrier between timer control and its clock prescaler
`timescale 1ns/1ps
interface timer_cfg_if;
  import timer_pkg::*;
  count_source_e countSource;
  logic [1:0]    prescaleRatio;
  logic [3:0]    sourceEdge;
  logic          prescaledTick;

  modport ctrl (output countSource, output prescaleRatio, output sourceEdge,
                input prescaledTick);
  modport gen  (input countSource, input prescaleRatio, input sourceEdge,
                output prescaledTick);
endinterface

// File: rtl/timer_prescaler.sv
// source selection and prescaler for the programmable down timer
`timescale 1ns/1ps
`include "programmable_down_timer_consts.svh"
module timer_prescaler
  import timer_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  timer_cfg_if.gen  cfg
);

  logic [7:0] divCount_reg;
  logic [7:0] divLimit;
  logic       srcEdge;
  logic       tick_reg;

  // ***************************
  // ratio decode
  // ***************************
  function automatic logic [7:0] ratioOf(input logic [1:0] code);
    unique case (code)
      2'h0: ratioOf = `PS_DIV_0;
      2'h1: ratioOf = `PS_DIV_1;
      2'h2: ratioOf = `PS_DIV_2;
      2'h3: ratioOf = `PS_DIV_3;
    endcase
  endfunction

  always_comb begin
    divLimit = ratioOf(cfg.prescaleRatio) - 8'h01;
    srcEdge  = cfg.sourceEdge[cfg.countSource];
  end

  // ***************************
  // divider
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      divCount_reg <= `RST_BYTE;
      tick_reg     <= `RST_BIT;
    end else begin
      tick_reg <= 1'b0;
      if (srcEdge) begin
        if (divCount_reg >= divLimit) begin
          divCount_reg <= `RST_BYTE;
          tick_reg     <= 1'b1;
        end else begin
          divCount_reg <= divCount_reg + 8'h01;
        end
      end
    end
  end

  assign cfg.prescaledTick = tick_reg;

endmodule

// File: rtl/programmable_down_timer.sv
// programmable 8-bit down timer with nibble-wide register port
`timescale 1ns/1ps
`include "programmable_down_timer_consts.svh"
module programmable_down_timer
  import timer_pkg::*;
#(
  parameter int NR_FAST_CYCLES = `CLK_HZ / `NR_FAST_HZ,
  parameter int NR_SLOW_CYCLES = `CLK_HZ / `NR_SLOW_HZ
)(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [3:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic [3:0]      regRdData,
  input  wire logic       highSpeedOscillator,
  input  wire logic       lowSpeedOscillator,
  input  wire logic       externalCountPin,
  input  wire logic       overflowPinSelect,
  output logic            overflowPinOut,
  output logic            overflowPinOe,
  output logic            timerIrqReq
);

  // ***************************
  // declarations
  // ***************************
  logic [1:0]       prescaleRatioField_reg;
  count_source_e    countSourceField_reg;
  logic             filterRateBit_reg;
  logic             overflowOutEnable_reg;
  logic             countRunBit_reg;
  logic [7:0]       reloadValue_reg;
  logic [7:0]       countValue_reg;
  logic             timerIrqMask_reg;
  logic             timerIrqFlag_reg;
  logic             overflowSignal_reg;
  logic [3:0]       regRdData_reg;
  logic             overflowPinOut_reg;
  logic             overflowPinOe_reg;
  logic             timerIrqReq_reg;
  logic             forceReload;
  logic             flagRead;
  logic [2:0]       rawIn;
  logic [2:0]       syncA_reg;
  logic [2:0]       syncB_reg;
  logic [2:0]       syncC_reg;
  logic [2:0]       stable_reg;
  logic [2:0]       stablePrev_reg;
  logic [2:0]       riseEdge;
  logic [`NR_CNT_W-1:0] nrCount_reg;
  logic [`NR_CNT_W-1:0] nrLimit;
  logic             nrTick_reg;
  rejector_state_e  nrState_reg;
  logic             filteredEdge_reg;

  timer_cfg_if cfg ();

  // ***************************
  // register decode
  // ***************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offs);
    hit = (addr == offs);
  endfunction

  assign forceReload = regWrEn && hit(regAddr, `ADDR_CONTROL)
                       && regWrData[`CTRL_FORCE_RELOAD];
  assign flagRead    = regRdEn && hit(regAddr, `ADDR_IRQ_FLAG);

  // ***************************
  // prescale and source fields
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      prescaleRatioField_reg <= `RST_FIELD2;
      countSourceField_reg   <= SRC_FILTERED;
    end else if (regWrEn) begin
      if (hit(regAddr, `ADDR_PRESCALE)) begin
        prescaleRatioField_reg <= regWrData[1:0];
      end
      if (hit(regAddr, `ADDR_SOURCE)) begin
        countSourceField_reg <= count_source_e'(regWrData[1:0]);
      end
    end
  end

  // ***************************
  // control bits
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      filterRateBit_reg     <= `RST_BIT;
      overflowOutEnable_reg <= `RST_BIT;
      countRunBit_reg       <= `RST_BIT;
    end else if (regWrEn && hit(regAddr, `ADDR_CONTROL)) begin
      filterRateBit_reg     <= regWrData[`CTRL_FILTER_RATE];
      overflowOutEnable_reg <= regWrData[`CTRL_OUT_ENABLE];
      countRunBit_reg       <= regWrData[`CTRL_RUN];
    end
  end

  // ***************************
  // reload value
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      reloadValue_reg <= `RST_BYTE;
    end else if (regWrEn) begin
      if (hit(regAddr, `ADDR_RELOAD_LO)) begin
        reloadValue_reg[3:0] <= regWrData;
      end
      if (hit(regAddr, `ADDR_RELOAD_HI)) begin
        reloadValue_reg[7:4] <= regWrData;
      end
    end
  end

  // ***************************
  // interrupt mask
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      timerIrqMask_reg <= `RST_BIT;
    end else if (regWrEn && hit(regAddr, `ADDR_IRQ_MASK)) begin
      timerIrqMask_reg <= regWrData[0];
    end
  end

  // ***************************
  // input synchronisers
  // ***************************
  assign rawIn = {externalCountPin, lowSpeedOscillator, highSpeedOscillator};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gSync
      always_ff @(posedge clk) begin
        if (rst) begin
          syncA_reg[gi]      <= 1'b0;
          syncB_reg[gi]      <= 1'b0;
          syncC_reg[gi]      <= 1'b0;
          stable_reg[gi]     <= 1'b0;
          stablePrev_reg[gi] <= 1'b0;
        end else begin
          syncA_reg[gi]      <= rawIn[gi];
          syncB_reg[gi]      <= syncA_reg[gi];
          syncC_reg[gi]      <= syncB_reg[gi];
          stablePrev_reg[gi] <= stable_reg[gi];
          if (syncB_reg[gi] == syncC_reg[gi]) begin
            stable_reg[gi] <= syncC_reg[gi];
          end
        end
      end
      assign riseEdge[gi] = stable_reg[gi] && !stablePrev_reg[gi];
    end
  endgenerate

  // ***************************
  // noise rejector sampling clock
  // ***************************
  assign nrLimit = filterRateBit_reg
                   ? `NR_CNT_W'(NR_FAST_CYCLES - 1)
                   : `NR_CNT_W'(NR_SLOW_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      nrCount_reg <= '0;
      nrTick_reg  <= 1'b0;
    end else if (nrCount_reg >= nrLimit) begin
      nrCount_reg <= '0;
      nrTick_reg  <= 1'b1;
    end else begin
      nrCount_reg <= nrCount_reg + `NR_CNT_W'(1);
      nrTick_reg  <= 1'b0;
    end
  end

  // ***************************
  // noise rejector
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      nrState_reg      <= NR_LOW;
      filteredEdge_reg <= 1'b0;
    end else begin
      filteredEdge_reg <= 1'b0;
      if (nrTick_reg) begin
        unique case (nrState_reg)
          NR_LOW: begin
            if (stable_reg[2]) begin
              nrState_reg <= NR_RISE_CHK;
            end
          end
          NR_RISE_CHK: begin
            if (stable_reg[2]) begin
              nrState_reg      <= NR_HIGH;
              filteredEdge_reg <= 1'b1;
            end else begin
              nrState_reg <= NR_LOW;
            end
          end
          NR_HIGH: begin
            if (!stable_reg[2]) begin
              nrState_reg <= NR_FALL_CHK;
            end
          end
          NR_FALL_CHK: begin
            if (!stable_reg[2]) begin
              nrState_reg <= NR_LOW;
            end else begin
              nrState_reg <= NR_HIGH;
            end
          end
        endcase
      end
    end
  end

  // ***************************
  // prescaler
  // ***************************
  assign cfg.countSource   = countSourceField_reg;
  assign cfg.prescaleRatio = prescaleRatioField_reg;
  assign cfg.sourceEdge    = {riseEdge[0], riseEdge[1], riseEdge[2], filteredEdge_reg};

  timer_prescaler uPrescaler (
    .clk (clk),
    .rst (rst),
    .cfg (cfg)
  );

  // ***************************
  // down counter
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      countValue_reg     <= `RST_BYTE;
      overflowSignal_reg <= 1'b0;
    end else begin
      overflowSignal_reg <= 1'b0;
      if (forceReload) begin
        countValue_reg <= reloadValue_reg;
      end else if (countRunBit_reg && cfg.prescaledTick) begin
        if (countValue_reg == `RST_BYTE) begin
          countValue_reg     <= reloadValue_reg;
          overflowSignal_reg <= 1'b1;
        end else begin
          countValue_reg <= countValue_reg - 8'h01;
        end
      end
    end
  end

  // ***************************
  // interrupt factor flag
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      timerIrqFlag_reg <= `RST_BIT;
    end else if (overflowSignal_reg) begin
      timerIrqFlag_reg <= 1'b1;
    end else if (flagRead) begin
      timerIrqFlag_reg <= 1'b0;
    end
  end

  // ***************************
  // read port
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData_reg <= `RST_NIBBLE;
    end else if (regRdEn) begin
      regRdData_reg <= `RST_NIBBLE;
      if (hit(regAddr, `ADDR_PRESCALE)) begin
        regRdData_reg <= {2'h0, prescaleRatioField_reg};
      end
      if (hit(regAddr, `ADDR_SOURCE)) begin
        regRdData_reg <= {2'h0, countSourceField_reg};
      end
      if (hit(regAddr, `ADDR_CONTROL)) begin
        regRdData_reg <= {filterRateBit_reg, overflowOutEnable_reg,
                          countRunBit_reg, 1'b0};
      end
      if (hit(regAddr, `ADDR_RELOAD_LO)) begin
        regRdData_reg <= reloadValue_reg[3:0];
      end
      if (hit(regAddr, `ADDR_RELOAD_HI)) begin
        regRdData_reg <= reloadValue_reg[7:4];
      end
      if (hit(regAddr, `ADDR_COUNT_LO)) begin
        regRdData_reg <= countValue_reg[3:0];
      end
      if (hit(regAddr, `ADDR_COUNT_HI)) begin
        regRdData_reg <= countValue_reg[7:4];
      end
      if (hit(regAddr, `ADDR_IRQ_MASK)) begin
        regRdData_reg <= {3'h0, timerIrqMask_reg};
      end
      if (hit(regAddr, `ADDR_IRQ_FLAG)) begin
        regRdData_reg <= {3'h0, timerIrqFlag_reg};
      end
    end
  end

  // ***************************
  // outputs
  // ***************************
  always_ff @(posedge clk) begin
    if (rst) begin
      overflowPinOut_reg <= 1'b0;
      overflowPinOe_reg  <= 1'b0;
    end else begin
      overflowPinOe_reg  <= overflowPinSelect;
      overflowPinOut_reg <= overflowSignal_reg && overflowOutEnable_reg
                            && overflowPinSelect;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timerIrqReq_reg <= 1'b0;
    end else begin
      timerIrqReq_reg <= timerIrqFlag_reg && timerIrqMask_reg;
    end
  end

  assign regRdData      = regRdData_reg;
  assign overflowPinOut = overflowPinOut_reg;
  assign overflowPinOe  = overflowPinOe_reg;
  assign timerIrqReq    = timerIrqReq_reg;

endmodule

// File: sim/timer_source_model.sv
// source clocks and event pin model for the timer far side
`timescale 1ns/1ps
module timer_source_model (
  input  wire logic clk,
  output logic      highSpeedOscillator,
  output logic      lowSpeedOscillator,
  output logic      externalCountPin
);
  logic [15:0] tick = 16'h0000;

  always @(posedge clk) begin
    tick <= tick + 16'h0001;
  end

  // periods of 4, 16 and 64 clocks
  assign highSpeedOscillator = tick[1];
  assign lowSpeedOscillator  = tick[3];
  assign externalCountPin    = tick[5];
endmodule

// File: sim/programmable_down_timer_monitor.sv
// port checker for the programmable down timer
`timescale 1ns/1ps
module timer_port_monitor #(
  parameter int NR_FAST_CYCLES = 4,
  parameter int NR_SLOW_CYCLES = 8
)(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] regAddr,
  input wire logic [3:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [3:0] regRdData,
  input wire logic       overflowPinSelect,
  input wire logic       overflowPinOut,
  input wire logic       overflowPinOe,
  input wire logic       timerIrqReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RESET_OUTS: assert property (disable iff (1'b0) rst |=> regRdData == 4'h0
    && !overflowPinOut && !overflowPinOe && !timerIrqReq) else $error("outputs not cleared");
  AST_OE_FOLLOWS: assert property (!rst |=> overflowPinOe == $past(overflowPinSelect))
    else $error("pin enable not following select");
  AST_OUT_NEEDS_OE: assert property (overflowPinOut |-> overflowPinOe)
    else $error("overflow driven on unselected pin");
  AST_OUT_PULSE: assert property (overflowPinOut |=> !overflowPinOut)
    else $error("overflow longer than one cycle");
  AST_IRQ_MASKED: assert property (regWrEn && regAddr == 8'hF0 && !regWrData[0]
    |-> ##2 !timerIrqReq) else $error("request while masked");
  AST_PRESCALE_RSVD: assert property (regRdEn && regAddr == 8'hE8
    |=> regRdData[3:2] == 2'h0) else $error("prescale upper bits nonzero");
  AST_FLAG_RSVD: assert property (regRdEn && regAddr == 8'hF8
    |=> regRdData[3:1] == 3'h0) else $error("flag upper bits nonzero");
  AST_RELOAD_BIT_RD: assert property (regRdEn && regAddr == 8'hEA
    |=> !regRdData[0]) else $error("reload bit reads one");
  AST_RELOAD_RB: assert property (regWrEn && regAddr == 8'hEB ##2 regRdEn && !regWrEn
    && regAddr == 8'hEB |=> regRdData == $past(regWrData, 3)) else $error("reload readback");
endmodule

bind programmable_down_timer timer_port_monitor #(
  .NR_FAST_CYCLES(NR_FAST_CYCLES),
  .NR_SLOW_CYCLES(NR_SLOW_CYCLES)
) mon (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .overflowPinSelect(overflowPinSelect),
  .overflowPinOut(overflowPinOut), .overflowPinOe(overflowPinOe), .timerIrqReq(timerIrqReq)
);

// File: sim/programmable_down_timer_tb.sv
// self-checking bench for the programmable down timer
`timescale 1ns/1ps
module programmable_down_timer_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [3:0]  regWrData = 4'h0;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic        overflowPinSelect = 1'b0;
  logic [3:0]  regRdData, nib;
  logic        hiOsc, loOsc, evPin, overflowPinOut, overflowPinOe, timerIrqReq;
  logic [7:0]  cnt, cnt2, dec;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          pulses = 0;
  logic [7:0]  rstAddr [10] = '{8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hF0,
                                8'hF8, 8'hE0};
  // {rate,src} {ratio} {expected decrement}
  logic [15:0] runs [6] = '{16'h3208, 16'h2110, 16'h3302, 16'h1104, 16'h8010, 16'h0010};

  always #10 clk = ~clk;

  programmable_down_timer #(.NR_FAST_CYCLES(4), .NR_SLOW_CYCLES(8)) DUT (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .highSpeedOscillator(hiOsc),
    .lowSpeedOscillator(loOsc), .externalCountPin(evPin),
    .overflowPinSelect(overflowPinSelect), .overflowPinOut(overflowPinOut),
    .overflowPinOe(overflowPinOe), .timerIrqReq(timerIrqReq));

  timer_source_model far (.clk(clk), .highSpeedOscillator(hiOsc),
    .lowSpeedOscillator(loOsc), .externalCountPin(evPin));

  // ****************
  // tasks
  // ****************
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk) regWrEn <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk) regRdEn <= 1'b0;
    @(posedge clk) nib = regRdData;
  endtask

  task automatic rd_cnt(output logic [7:0] c);
    rd(8'hED);
    c[3:0] = nib;
    rd(8'hEE);
    c[7:4] = nib;
  endtask

  always @(posedge clk) begin
    if (overflowPinOut === 1'b1) pulses <= pulses + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'hED, 4'hF);
    wr(8'hEE, 4'hF);
    wr(8'hF8, 4'hF);
    foreach (rstAddr[i]) begin
      rd(rstAddr[i]);
      check(nib, 8'h00);
    end
    $display("test reset values done");
    wr(8'hE8, 4'hF);
    rd(8'hE8);
    check(nib, 8'h03);
    wr(8'hEA, 4'hF);
    rd(8'hEA);
    check(nib, 8'h0E);
    wr(8'hEA, 4'h0);
    wr(8'hEB, 4'hA);
    rd(8'hEB);
    check(nib, 8'h0A);
    wr(8'hEC, 4'h5);
    rd(8'hEC);
    check(nib, 8'h05);
    wr(8'hEA, 4'h1);
    rd_cnt(cnt);
    check(cnt, 8'h5A);
    $display("test reload done");
    wr(8'hEB, 4'hF);
    wr(8'hEC, 4'hF);
    foreach (runs[i]) begin
      wr(8'hE9, {2'h0, runs[i][13:12]});
      wr(8'hE8, {2'h0, runs[i][9:8]});
      wr(8'hEA, {runs[i][15], 3'h3});
      repeat (1024) @(posedge clk);
      wr(8'hEA, {runs[i][15], 3'h0});
      rd_cnt(cnt);
      repeat (100) @(posedge clk);
      rd_cnt(cnt2);
      check(cnt2, cnt);
      dec = 8'hFF - cnt;
      check({7'h0, dec + 8'h01 >= runs[i][7:0] && dec <= runs[i][7:0] + 8'h01}, 8'h01);
    end
    $display("test sources and ratios done");
    wr(8'hEB, 4'h3);
    wr(8'hEC, 4'h0);
    wr(8'hE9, 4'h3);
    wr(8'hE8, 4'h0);
    wr(8'hF0, 4'h1);
    rd(8'hF0);
    check(nib, 8'h01);
    overflowPinSelect <= 1'b1;
    wr(8'hEA, 4'h7);
    pulses = 0;
    repeat (320) @(posedge clk);
    check({7'h0, pulses >= 19 && pulses <= 21}, 8'h01);
    check({7'h0, timerIrqReq}, 8'h01);
    wr(8'hEA, 4'h0);
    wr(8'hF0, 4'h0);
    @(posedge clk);
    check({7'h0, timerIrqReq}, 8'h00);
    rd(8'hF8);
    check(nib, 8'h01);
    rd(8'hF8);
    check(nib, 8'h00);
    $display("test underflow done");
    for (int k = 0; k < 2; k++) begin
      overflowPinSelect <= k[0];
      wr(8'hEA, k ? 4'h3 : 4'h7);
      pulses = 0;
      repeat (160) @(posedge clk);
      check(pulses[7:0], 8'h00);
      check({7'h0, overflowPinOe}, {7'h0, k[0]});
      wr(8'hEA, 4'h0);
    end
    $display("test output gating done");
    end_sim();
  end
endmodule
